// *** esr_pkg.sv ***
// =============================================
// shared constants of the mask block
package esr_pkg;
    // register select codes on the command port
    localparam logic [1:0] SEL_JUDGE     = 2'h1;
    localparam logic [1:0] SEL_LOW_BIN   = 2'h2;
    localparam logic [1:0] SEL_HIGH_BIN  = 2'h3;
    // reset values
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    // largest legal mask value
    localparam logic [15:0] MASK_MAX     = 16'h00FF;
    // judgement register field positions
    localparam int JUDGE_FIRST_HIGH  = 0;
    localparam int JUDGE_FIRST_IN    = 1;
    localparam int JUDGE_FIRST_LOW   = 2;
    localparam int JUDGE_SECOND_HIGH = 3;
    localparam int JUDGE_SECOND_IN   = 4;
    localparam int JUDGE_SECOND_LOW  = 5;
    localparam int JUDGE_AND_PASS    = 6;
    localparam int JUDGE_ERROR       = 7;
    // high bin register field positions
    localparam int HIGH_BIN9         = 0;
    localparam int HIGH_LOW_CAP      = 5;
    localparam int HIGH_OUT_OF_BIN   = 6;
    localparam int HIGH_FAULT        = 7;
    // response state
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_RESP = 3'b100
    } resp_state_t;
endpackage

// *** mask_round.sv ***
`timescale 1ns/1ps
// =============================================
// rounds a fixed-point set value to an integer
module mask_round (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // fixed-point value: integer part and one fraction bit group
    input  wire logic        inValid,
    input  wire logic [15:0] inInt,
    input  wire logic [3:0]  inFrac,
    // rounded result, one cycle later
    output logic             outValid,
    output logic [7:0]       outValue,
    output logic             outRange
);
    logic [16:0] rounded;

    // half-up rounding: fraction nibble weighs 1/16
    always_comb begin
        rounded = {1'b0, inInt} + {16'h0000, inFrac[3]};
    end

    // register result and range verdict
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            outValid <= 1'b0;
            outValue <= 8'h00;
            outRange <= 1'b0;
        end else begin
            outValid <= inValid;
            outValue <= rounded[7:0];
            outRange <= (rounded <= {1'b0, esr_pkg::MASK_MAX}); // RULE12
        end
    end
endmodule

// *** event_status_enable_masks.sv ***
`timescale 1ns/1ps
// What this block does
// (RULE1) three 8-bit mask registers, each set to any value 0 to 255
// (RULE2) fractional set values are rounded to an integer before storing
// (RULE3) all masks are zero after power-on reset
// (RULE4) query returns the stored mask, reading leaves it unchanged
// (RULE5) judgement mask bits: first high/in/low, second high/in/low, and-pass, error
// (RULE6) low bin mask bits 0..7 enable bins 1..8
// (RULE7) high bin mask bits 0..4 bins 9..13, 5 low-cap, 6 out-of-bin, 7 fault
// (RULE8) header on: reply echoes command header; off: value only (status query replies here never carry the header)
// (RULE9) masks are binary weighted, bit n weighs 2 to the n
// (RULE10) status query returns 0..255 and clears the status register
// (RULE11) status bit counts toward summary only while its mask bit is one
// (RULE12) set value above 255 is a command error, mask unchanged
module event_status_enable_masks (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // set command from the parser
    input  wire logic       setValid,
    input  wire logic [1:0] setSel,
    input  wire logic [15:0] setInt,
    input  wire logic [3:0] setFrac,
    // mask query from the parser
    input  wire logic       maskQuery,
    input  wire logic [1:0] querySel,
    input  wire logic       headerOn,
    // status query from the parser (clear on read)
    input  wire logic       statusQuery,
    // raw events, one-cycle pulses from the measurement logic
    input  wire logic [7:0] judgeEvents,
    input  wire logic [7:0] lowBinEvents,
    input  wire logic [7:0] highBinEvents,
    // reply to the formatter
    output logic            respValid,
    output logic            respHeader,
    output logic [1:0]      respSel,
    output logic [7:0]      respValue,
    output logic            cmdError,
    // summary bits per register
    output logic [2:0]      summary
);
    // =============================================
    // storage
    // mask registers, loaded only by an accepted set
    logic [7:0]           judgement_event_enable_mask_q;
    logic [7:0]           low_bin_event_enable_mask_q;
    logic [7:0]           high_bin_event_enable_mask_q;
    // status registers, set by events and cleared by their own query
    logic [7:0]           judgeStat_q;
    logic [7:0]           lowStat_q;
    logic [7:0]           highStat_q;
    // per-bit status gated by its mask bit
    logic [7:0]           judgeHit;
    logic [7:0]           lowHit;
    logic [7:0]           highHit;
    // rounding stage results, one cycle behind the set strobe
    logic                 rndValid;
    logic [7:0]           rndValue;
    logic                 rndOk;
    logic [1:0]           pendSel_q;
    // query latch and read mux
    logic [1:0]           qSel_q;
    logic                 qHdr_q;
    logic                 qStat_q;
    logic [7:0]           readVal;
    esr_pkg::resp_state_t state_q;

    // =============================================
    // set path
    mask_round mask_round_inst (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .inValid  (setValid),
        .inInt    (setInt),
        .inFrac   (setFrac),
        .outValid (rndValid),
        .outValue (rndValue),
        .outRange (rndOk)
    ); // RULE2

    // remember which register the set aims at while rounding
    // a second set may follow at once: its select lands as the first one commits
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pendSel_q <= 2'h0;
        end else if (setValid) begin
            pendSel_q <= setSel;
        end
    end

    // =============================================
    // mask field map, bit 0 first; a one lets that event reach the summary
    //   judgement mask: 0 first high, 1 first in, 2 first low,
    //                   3 second high, 4 second in, 5 second low,
    //                   6 and-pass, 7 error
    //   low bin mask:   bit n enables bin n+1, so bin 1 sits in bit 0
    //   high bin mask:  0..4 bins 9..13, 5 low-cap, 6 out-of-bin, 7 fault
    // the rounded value is stored as it comes, so a host weight of 2 to the n
    // lands in bit n; no reordering happens here, and the event sources
    // must wire their pulses to these same positions
    // limitation: the mask never filters the status itself, only the summary

    // masks load the binary weighted value; out of range keeps the old one
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            judgement_event_enable_mask_q <= esr_pkg::MASK_RESET; // RULE3
            low_bin_event_enable_mask_q   <= esr_pkg::MASK_RESET; // RULE3
            high_bin_event_enable_mask_q  <= esr_pkg::MASK_RESET; // RULE3
        end else if (rndValid && rndOk) begin // RULE12
            case (pendSel_q)
                esr_pkg::SEL_JUDGE:    judgement_event_enable_mask_q <= rndValue; // RULE1 RULE9 RULE5
                esr_pkg::SEL_LOW_BIN:  low_bin_event_enable_mask_q   <= rndValue; // RULE6
                esr_pkg::SEL_HIGH_BIN: high_bin_event_enable_mask_q  <= rndValue; // RULE7
                default: begin
                end
            endcase
        end
    end

    // one-cycle error pulse on a rejected value
    // the host learns of a refused value only through this pulse
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmdError <= 1'b0;
        end else begin
            cmdError <= rndValid && !rndOk; // RULE12
        end
    end

    // =============================================
    // status registers: events set, a status read clears; a set wins over the clear
    // the clear hits only the register just read, and only in the answer cycle
    logic statClear;
    assign statClear = (state_q == esr_pkg::ST_RESP) && qStat_q;

    // event and clear in one cycle: the new event survives into the next read

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            judgeStat_q <= esr_pkg::STATUS_RESET;
            lowStat_q   <= esr_pkg::STATUS_RESET;
            highStat_q  <= esr_pkg::STATUS_RESET;
        end else begin
            judgeStat_q <= (statClear && qSel_q == esr_pkg::SEL_JUDGE    ? 8'h00 : judgeStat_q) | judgeEvents; // RULE10
            lowStat_q   <= (statClear && qSel_q == esr_pkg::SEL_LOW_BIN  ? 8'h00 : lowStat_q)   | lowBinEvents; // RULE10
            highStat_q  <= (statClear && qSel_q == esr_pkg::SEL_HIGH_BIN ? 8'h00 : highStat_q)  | highBinEvents; // RULE10
        end
    end

    // per-bit gating: a status bit counts only through its own mask bit
    for (genvar b = 0; b < 8; b++) begin : gen_gate
        assign judgeHit[b] = judgeStat_q[b] & judgement_event_enable_mask_q[b]; // RULE11
        assign lowHit[b]   = lowStat_q[b] & low_bin_event_enable_mask_q[b];     // RULE11
        assign highHit[b]  = highStat_q[b] & high_bin_event_enable_mask_q[b];   // RULE11
    end

    // summary registered so the output comes from a flop; it trails the status by a cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            summary <= 3'h0;
        end else begin
            summary[0] <= |judgeHit; // RULE11
            summary[1] <= |lowHit;   // RULE11
            summary[2] <= |highHit;  // RULE11
        end
    end

    // =============================================
    // query path: latch request, pick value, answer
    always_comb begin
        case (qSel_q)
            esr_pkg::SEL_JUDGE:    readVal = qStat_q ? judgeStat_q : judgement_event_enable_mask_q;
            esr_pkg::SEL_LOW_BIN:  readVal = qStat_q ? lowStat_q   : low_bin_event_enable_mask_q;
            esr_pkg::SEL_HIGH_BIN: readVal = qStat_q ? highStat_q  : high_bin_event_enable_mask_q;
            default:               readVal = 8'h00;
        endcase
    end

    // =============================================
    // query sequencer and reply register

    // queries arriving while busy are ignored; the parser serialises them
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q    <= esr_pkg::ST_IDLE;
            qSel_q     <= 2'h0;
            qHdr_q     <= 1'b0;
            qStat_q    <= 1'b0;
            respValid  <= 1'b0;
            respHeader <= 1'b0;
            respSel    <= 2'h0;
            respValue  <= 8'h00;
        end else begin
            respValid <= 1'b0;
            case (state_q)
                esr_pkg::ST_IDLE: begin
                    // take the request; later ones are dropped until the answer
                    if (maskQuery || statusQuery) begin
                        qSel_q  <= querySel;
                        qHdr_q  <= headerOn && !statusQuery; // RULE8
                        qStat_q <= statusQuery;
                        state_q <= esr_pkg::ST_READ;
                    end
                end
                esr_pkg::ST_READ: begin
                    // spare cycle: the read mux settles from the latched select
                    state_q <= esr_pkg::ST_RESP;
                end
                esr_pkg::ST_RESP: begin
                    // answer registered; a status read clears its register at this edge
                    respValid  <= 1'b1;
                    respValue  <= readVal; // RULE4
                    respHeader <= qHdr_q;  // RULE8
                    respSel    <= qSel_q;
                    state_q    <= esr_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= esr_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule

// *** event_status_enable_masks_assertions.sv ***
`timescale 1ns/1ps
// ==========
// port checks of the mask block
module event_status_enable_masks_assertions (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        arst_n,
    // commands
    input wire logic        setValid,
    input wire logic [15:0] setInt,
    input wire logic [3:0]  setFrac,
    input wire logic        maskQuery,
    input wire logic        statusQuery,
    input wire logic        headerOn,
    input wire logic [1:0]  querySel,
    // replies
    input wire logic        respValid,
    input wire logic        respHeader,
    input wire logic [7:0]  respValue,
    input wire logic [1:0]  respSel,
    input wire logic        cmdError
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // one bit wider so 65535 plus a round-up is not lost
    logic [16:0] rounded;
    assign rounded = {1'b0, setInt} + {16'h0000, setFrac[3]};
    AST_SET_BAD: assert property (setValid && rounded > 17'h000FF |-> ##2 cmdError)
        else $error("no command error");
    AST_SET_GOOD: assert property (setValid && rounded <= 17'h000FF |-> ##2 !cmdError)
        else $error("false command error");
    AST_MASK_LAT: assert property (maskQuery |-> !respValid [*3] ##1 respValid)
        else $error("reply latency");
    AST_MASK_HDR: assert property (maskQuery |-> ##3 respHeader == $past(headerOn, 3))
        else $error("header echo");
    AST_STAT_HDR: assert property (statusQuery |-> ##3 respValid && !respHeader)
        else $error("status reply");
    AST_SEL_ECHO: assert property ((maskQuery || statusQuery) |-> ##3 respSel == $past(querySel, 3))
        else $error("reply select");
    AST_ONE_SHOT: assert property (respValid |=> !respValid)
        else $error("reply too long");
    AST_NO_SPUR: assert property (respValid |-> $past(maskQuery || statusQuery, 3))
        else $error("reply unasked");
    AST_HOLD: assert property (!respValid |-> $stable(respValue))
        else $error("value moved");
    cover property (cmdError);
    cover property (statusQuery ##3 respValid);
    cover property (maskQuery && headerOn);
endmodule

// *** host_model.sv ***
`timescale 1ns/1ps
// ==========
// remote host: one command at a time, driven on the falling edge
module host_model (
    // clock
    input wire logic       sys_clk,
    // reply from the block
    input wire logic       respValid,
    input wire logic       respHeader,
    input wire logic [7:0] respValue
);
    logic        setValid = 1'b0, maskQuery = 1'b0, statusQuery = 1'b0, headerOn = 1'b0, hung = 1'b0;
    logic [1:0]  setSel = 2'h0, querySel = 2'h0;
    logic [15:0] setInt = 16'h0000;
    logic [3:0]  setFrac = 4'h0;
    logic [7:0]  events = 8'h00;
    // set, then idle until the mask has landed two edges on
    task automatic setMask(input logic [1:0] s, input logic [15:0] i, input logic [3:0] f);
        @(negedge sys_clk) {setValid, setSel, setInt, setFrac} <= {1'b1, s, i, f};
        @(negedge sys_clk) setValid <= 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    // query; busy cycles would swallow a second one, so wait for the reply
    task automatic ask(input logic st, input logic [1:0] s, input logic h, output logic [7:0] v, output logic hd);
        int n;
        @(negedge sys_clk) {statusQuery, maskQuery, querySel, headerOn} <= {st, !st, s, h};
        @(negedge sys_clk) {statusQuery, maskQuery} <= 2'b00;
        for (n = 0; n < 8 && respValid !== 1'b1; n++) @(negedge sys_clk);
        hung = (n == 8);
        v = respValue;
        hd = respHeader;
    endtask
    // one-cycle event pulse on all three groups
    task automatic pulse(input logic [7:0] e);
        @(negedge sys_clk) events <= e;
        @(negedge sys_clk) events <= 8'h00;
        @(negedge sys_clk);
    endtask
endmodule

// *** event_status_enable_masks_tb.sv ***
`timescale 1ns/1ps
// ==========
// bench: host issues commands, expected masks tracked here
module event_status_enable_masks_tb;
    logic       sys_clk = 1'b0, arst_n = 1'b0, respValid, respHeader, cmdError, h;
    logic [1:0] respSel;
    logic [2:0] summary;
    logic [7:0] respValue, v;
    logic [7:0] m [1:3];
    int         mismatches = 0, comparisons = 0;
    // 25 MHz clock
    initial forever #20 sys_clk = ~sys_clk;
    host_model host (.sys_clk(sys_clk), .respValid(respValid), .respHeader(respHeader), .respValue(respValue));
    event_status_enable_masks event_status_enable_masks_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .setValid(host.setValid), .setSel(host.setSel), .setInt(host.setInt), .setFrac(host.setFrac),
        .maskQuery(host.maskQuery), .querySel(host.querySel), .headerOn(host.headerOn),
        .statusQuery(host.statusQuery), .judgeEvents(host.events), .lowBinEvents(host.events),
        .highBinEvents(host.events), .respValid(respValid), .respHeader(respHeader), .respSel(respSel),
        .respValue(respValue), .cmdError(cmdError), .summary(summary));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // set and track: out-of-range and select 0 leave the mask alone
    task automatic put(input logic [1:0] s, input logic [15:0] i, input logic [3:0] f);
        host.setMask(s, i, f);
        if (s != 2'h0 && i + f[3] < 17'h00100) m[s] = 8'(i + f[3]);
    endtask
    // query and compare; a lost reply ends the run
    task automatic look(input logic st, input logic [1:0] s, input logic hd, input logic [7:0] e);
        host.ask(st, s, hd, v, h);
        if (host.hung) begin
            mismatches++;
            summarize;
        end
        check(v, e);
        check({7'h00, h}, {7'h00, hd & ~st});
        check({6'h00, respSel}, {6'h00, s});
    endtask
    // main sequence
    initial begin
        repeat (12) @(negedge sys_clk);
        arst_n <= 1'b1;
        for (int s = 1; s < 4; s++) begin
            m[s] = 8'h00;
            look(1'b0, 2'(s), 1'(s), 8'h00);
        end
        $display("reset test done");
        for (int s = 1; s < 4; s++) put(2'(s), 16'h0001 << (3 * s - 3), 4'h0);
        for (int s = 1; s < 4; s++) look(1'b0, 2'(s), 1'b1, m[s]);
        $display("weight test done");
        put(2'h1, 16'h00FE, 4'h8);
        put(2'h3, 16'h0041, 4'h7);
        put(2'h1, 16'h00FF, 4'h8);
        put(2'h2, 16'h0100, 4'h7);
        put(2'h0, 16'h0005, 4'h0);
        for (int s = 1; s < 4; s++) look(1'b0, 2'(s), 1'b0, m[s]);
        $display("range test done");
        host.pulse(8'hC1);
        check({5'h00, summary}, {5'h00, |(8'hC1 & m[3]), |(8'hC1 & m[2]), |(8'hC1 & m[1])});
        look(1'b1, 2'h1, 1'b1, 8'hC1);
        look(1'b1, 2'h1, 1'b1, 8'h00);
        check({5'h00, summary}, {5'h00, |(8'hC1 & m[3]), |(8'hC1 & m[2]), 1'b0});
        look(1'b1, 2'h3, 1'b0, 8'hC1);
        look(1'b1, 2'h2, 1'b0, 8'hC1);
        check({5'h00, summary}, 8'h00);
        look(1'b0, 2'h0, 1'b1, 8'h00);
        $display("status test done");
        @(negedge sys_clk) arst_n <= 1'b0;
        repeat (3) @(negedge sys_clk);
        arst_n <= 1'b1;
        for (int s = 1; s < 4; s++) look(1'b0, 2'(s), 1'b0, 8'h00);
        $display("second reset test done");
        summarize;
    end
endmodule
bind event_status_enable_masks event_status_enable_masks_assertions event_status_enable_masks_assertions_inst (
    .sys_clk, .arst_n, .setValid, .setInt, .setFrac, .maskQuery, .statusQuery, .headerOn, .querySel,
    .respValid, .respHeader, .respValue, .respSel, .cmdError);
